//--- ssp_params.svh
// constants for the synchronous serial port pin block
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

// ==========================================================
// pin indices into the six-line pin vectors
`define SSP_PIN_TXD 0
`define SSP_PIN_RXD 1
`define SSP_PIN_SCK 2
`define SSP_PIN_CTL0 3
`define SSP_PIN_CTL1 4
`define SSP_PIN_FS 5
`define SSP_PIN_COUNT 6

// ==========================================================
// word and buffer sizes
`define SSP_WORD_BITS 16
`define SSP_FIFO_DEPTH 8
`define SSP_TX_LANES 3

// ==========================================================
// timing: system clock and generated bit clock periods in ns
`define SSP_MCLK_NS 40
`define SSP_BIT_CLK_NS 320
`define SSP_HALF_BIT_CYCLES ((`SSP_BIT_CLK_NS / 2) / `SSP_MCLK_NS)

// ==========================================================
// reset values of pin drive
`define SSP_RST_PIN_OUT 6'h00
`define SSP_RST_PIN_OE 6'h00

`endif

//--- ssp_pkg.sv
// shared types of the synchronous serial port pin block
package ssp_pkg;

  // operating mode of the three control pins
  typedef enum logic {
    SSP_MODE_SYNC,
    SSP_MODE_ASYNC
  } ssp_mode_e;

endpackage

//--- ssp_fifo.sv
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
`include "ssp_params.svh"

module ssp_fifo #(
  parameter int WIDTH = `SSP_WORD_BITS,
  parameter int DEPTH = `SSP_FIFO_DEPTH
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // all state of the fifo
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // storage words
    logic [AW-1:0] wr; // write index
    logic [AW-1:0] rd; // read index
    logic [AW:0] cnt; // words held
  } ssp_fifo_s;

  ssp_fifo_s r;
  ssp_fifo_s next_r;
  logic push;
  logic pop;

  // wrap an index at the depth, works for depths that are not powers of two
  function automatic logic [AW-1:0] ssp_inc(input logic [AW-1:0] p);
    ssp_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // ==========================================================
  // handshake
  assign in_ready_out = (r.cnt != (AW + 1)'(DEPTH));
  assign out_valid_out = (r.cnt != '0);
  assign out_data_out = r.mem[r.rd];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // next state
  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wr] = in_data_in;
      next_r.wr = ssp_inc(r.wr);
    end
    if (pop) begin
      next_r.rd = ssp_inc(r.rd);
    end
    // simultaneous push and pop leaves the count alone
    if (push && !pop) begin
      next_r.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      next_r.cnt = r.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule

//--- ssp_pins.sv
// pin-level logic of the synchronous serial port with pin fallback to general lines
`timescale 1ns/100ps
`include "ssp_params.svh"

// Summary of operation
// RQ1: transmit pin sends transmit shift register bits
// RQ2: receive pin bits enter receive shift register
// RQ3: bit clock pin driven by port or peer
// RQ4: bit clock continuous or gated to words
// RQ5: synchronous mode: one clock times both directions
// RQ6: asynchronous: control zero is receive clock
// RQ7: synchronous: control zero second transmitter or flag
// RQ8: asynchronous: control one is receive frame sync
// RQ9: synchronous: control one third transmitter or flag
// RQ10: control two is the shared/transmit frame sync
// RQ11: output frame sync pin carries internal sync
// RQ12: input frame sync supplied by the peer
// RQ13: unused port pins become general purpose lines
// RQ14: one mode setting switches all control pins
module ssp_pins #(
  parameter int WORD_BITS = `SSP_WORD_BITS,
  parameter int FIFO_DEPTH = `SSP_FIFO_DEPTH,
  parameter int HALF_BIT_CYCLES = `SSP_HALF_BIT_CYCLES
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic port_enable_in,
  input wire logic sync_mode_in,
  input wire logic bit_clock_master_in,
  input wire logic clock_gated_in,
  input wire logic frame_master_in,
  input wire logic rx_clock_master_in,
  input wire logic rx_frame_master_in,
  input wire logic [1:0] ctl_tx_lane_in,
  input wire logic [1:0] flag_dir_in,
  input wire logic [1:0] flag_value_in,
  output logic [1:0] flag_state_out,
  input wire logic [`SSP_PIN_COUNT-1:0] gpio_dir_in,
  input wire logic [`SSP_PIN_COUNT-1:0] gpio_data_in,
  output logic [`SSP_PIN_COUNT-1:0] gpio_level_out,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  input wire logic [WORD_BITS-1:0] tx_data_in,
  input wire logic [WORD_BITS-1:0] tx1_data_in,
  input wire logic [WORD_BITS-1:0] tx2_data_in,
  output logic rx_valid_out,
  output logic [WORD_BITS-1:0] rx_data_out,
  input wire logic [`SSP_PIN_COUNT-1:0] pin_in,
  output logic [`SSP_PIN_COUNT-1:0] pin_out,
  output logic [`SSP_PIN_COUNT-1:0] pin_oe_out
);

  // ==========================================================
  // local sizes
  localparam int NP = `SSP_PIN_COUNT;
  localparam int CW = $clog2(WORD_BITS + 1);
  localparam int DW = (HALF_BIT_CYCLES > 1) ? $clog2(HALF_BIT_CYCLES) : 1;
  localparam int LW = `SSP_TX_LANES * WORD_BITS;

  // all state of the block
  typedef struct packed {
    logic [NP-1:0] sync1; // first synchroniser stage, read only by sync2
    logic [NP-1:0] sync2; // settled pin levels
    logic [NP-1:0] sync3; // previous settled levels for edge finding
    logic [DW-1:0] div_cnt; // half bit divider
    logic bclk; // generated bit clock
    logic [WORD_BITS-1:0] tx_sh0; // primary transmit shift register
    logic [WORD_BITS-1:0] tx_sh1; // second transmitter shift register
    logic [WORD_BITS-1:0] tx_sh2; // third transmitter shift register
    logic [2:0] tx_bits; // bits now on the three transmit lanes
    logic [CW-1:0] tx_cnt; // bits sent of the current word
    logic tx_pend; // frame sync seen, word starts at next rising edge
    logic fs_gen; // generated shared/transmit frame sync
    logic [WORD_BITS-1:0] rx_sh; // receive shift register
    logic [CW-1:0] rx_cnt; // bits received of the current word
    logic rx_pend; // receive frame sync seen
    logic rxfs_gen; // generated receive frame sync, asynchronous mode
    logic [WORD_BITS-1:0] rx_data; // last whole received word
    logic rx_valid; // one-cycle word strobe
    logic [NP-1:0] pin_out; // registered pin drive values
    logic [NP-1:0] pin_oe; // registered pin enables
  } ssp_state_s;

  ssp_state_s r;
  ssp_state_s next_r;

  // fifo drain side
  logic fifo_valid;
  logic fifo_ready;
  logic [LW-1:0] fifo_data;

  // combinational helpers
  ssp_pkg::ssp_mode_e mode;
  logic [NP-1:0] rise;
  logic [NP-1:0] fall;
  logic int_rise;
  logic int_fall;
  logic run;
  logic tx_rise;
  logic tx_fall;
  logic rx_rise;
  logic rx_fall;
  logic tx_fs;
  logic rx_fs;
  logic [CW-1:0] rx_cnt_new;
  logic [WORD_BITS-1:0] rx_sh_new;

  // ==========================================================
  // transmit word buffer: three lanes per entry, back-pressure on tx_ready_out
  ssp_fifo #(
    .WIDTH(LW),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .in_valid_in(tx_valid_in),
    .in_ready_out(tx_ready_out),
    .in_data_in({tx2_data_in, tx1_data_in, tx_data_in}),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_ready),
    .out_data_out(fifo_data)
  );

  // ==========================================================
  // outputs straight from flip-flops
  assign pin_out = r.pin_out;
  assign pin_oe_out = r.pin_oe;
  assign rx_valid_out = r.rx_valid;
  assign rx_data_out = r.rx_data;
  assign gpio_level_out = r.sync2;
  assign flag_state_out = {r.sync2[`SSP_PIN_CTL1], r.sync2[`SSP_PIN_CTL0]};

  // a word is popped on the rising edge that starts it
  assign fifo_ready = tx_rise & r.tx_pend & port_enable_in;

  // ==========================================================
  // clock and frame selection
  always_comb begin
    mode = ssp_pkg::ssp_mode_e'(sync_mode_in ? 1'b0 : 1'b1); // see RQ14
    rise = r.sync2 & ~r.sync3;
    fall = ~r.sync2 & r.sync3;
    // gated clock runs only while a word is queued, pending or moving
    run = !clock_gated_in || fifo_valid || r.tx_pend || r.fs_gen || (r.tx_cnt != '0) ||
          r.rxfs_gen || r.rx_pend || (r.rx_cnt != '0); // see RQ4
    run = run && port_enable_in;
    int_rise = 1'b0;
    int_fall = 1'b0;
    if ((run || r.bclk) && (r.div_cnt == DW'(HALF_BIT_CYCLES - 1))) begin
      int_rise = !r.bclk;
      int_fall = r.bclk;
    end
    // port or peer owns the bit clock
    tx_rise = bit_clock_master_in ? int_rise : rise[`SSP_PIN_SCK]; // see RQ3
    tx_fall = bit_clock_master_in ? int_fall : fall[`SSP_PIN_SCK];
    tx_fs = frame_master_in ? r.fs_gen : r.sync2[`SSP_PIN_FS]; // see RQ12
    if (mode == ssp_pkg::SSP_MODE_SYNC) begin
      // one clock and one frame sync for both directions
      rx_rise = tx_rise; // see RQ5
      rx_fall = tx_fall;
      rx_fs = tx_fs; // see RQ10
    end else begin
      // receiver has its own clock on control zero and frame on control one
      rx_rise = rx_clock_master_in ? int_rise : rise[`SSP_PIN_CTL0]; // see RQ6
      rx_fall = rx_clock_master_in ? int_fall : fall[`SSP_PIN_CTL0];
      rx_fs = rx_frame_master_in ? r.rxfs_gen : r.sync2[`SSP_PIN_CTL1]; // see RQ8
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    next_r = r;
    next_r.rx_valid = 1'b0;
    rx_cnt_new = r.rx_cnt;
    rx_sh_new = r.rx_sh;

    // pin synchronisers: sync1 is read by nothing but sync2
    next_r.sync1 = pin_in;
    next_r.sync2 = r.sync1;
    next_r.sync3 = r.sync2;

    // bit clock divider, parks low when gated and idle
    if (run || r.bclk) begin
      if (r.div_cnt == DW'(HALF_BIT_CYCLES - 1)) begin
        next_r.div_cnt = '0;
        next_r.bclk = !r.bclk;
      end else begin
        next_r.div_cnt = r.div_cnt + 1'b1;
      end
    end else begin
      next_r.div_cnt = '0;
    end

    // transmitter: launch on rising edges
    if (tx_rise) begin
      if (r.tx_pend) begin
        // load all three lanes; an empty buffer sends zeros
        next_r.tx_sh0 = fifo_valid ? fifo_data[WORD_BITS-1:0] : '0;
        next_r.tx_sh1 = fifo_valid ? fifo_data[2*WORD_BITS-1:WORD_BITS] : '0;
        next_r.tx_sh2 = fifo_valid ? fifo_data[LW-1:2*WORD_BITS] : '0;
        next_r.tx_bits = {next_r.tx_sh2[WORD_BITS-1], next_r.tx_sh1[WORD_BITS-1],
                          next_r.tx_sh0[WORD_BITS-1]};
        next_r.tx_sh0 = {next_r.tx_sh0[WORD_BITS-2:0], 1'b0};
        next_r.tx_sh1 = {next_r.tx_sh1[WORD_BITS-2:0], 1'b0};
        next_r.tx_sh2 = {next_r.tx_sh2[WORD_BITS-2:0], 1'b0};
        next_r.tx_cnt = CW'(1);
        next_r.tx_pend = 1'b0;
      end else if (r.tx_cnt == CW'(WORD_BITS)) begin
        // word finished, lanes idle low
        next_r.tx_bits = 3'h0;
        next_r.tx_cnt = '0;
      end else if (r.tx_cnt != '0) begin
        // msb first shifting out of the shift registers
        next_r.tx_bits = {r.tx_sh2[WORD_BITS-1], r.tx_sh1[WORD_BITS-1], r.tx_sh0[WORD_BITS-1]}; // see RQ1
        next_r.tx_sh0 = {r.tx_sh0[WORD_BITS-2:0], 1'b0};
        next_r.tx_sh1 = {r.tx_sh1[WORD_BITS-2:0], 1'b0};
        next_r.tx_sh2 = {r.tx_sh2[WORD_BITS-2:0], 1'b0};
        next_r.tx_cnt = r.tx_cnt + 1'b1;
      end
      // generated frame sync is one bit wide and one bit ahead of the word
      next_r.fs_gen = frame_master_in && fifo_valid && !r.tx_pend && !r.fs_gen &&
                      ((r.tx_cnt == '0) || (r.tx_cnt == CW'(WORD_BITS))); // see RQ11
    end
    // frame sync is taken on falling edges, peer's or our own
    if (tx_fall && tx_fs) begin
      next_r.tx_pend = 1'b1; // see RQ12
    end

    // receive frame sync generator for asynchronous mode
    if (rx_rise) begin
      next_r.rxfs_gen = rx_frame_master_in && !r.rx_pend && !r.rxfs_gen &&
                        (r.rx_cnt == '0);
    end

    // receiver: sample on falling edges
    if (rx_fall) begin
      if (r.rx_pend || (r.rx_cnt != '0)) begin
        rx_sh_new = {r.rx_sh[WORD_BITS-2:0], r.sync2[`SSP_PIN_RXD]}; // see RQ2
        rx_cnt_new = r.rx_pend ? CW'(1) : r.rx_cnt + 1'b1;
        if (rx_cnt_new == CW'(WORD_BITS)) begin
          // whole word: hand out and wait for the next frame
          next_r.rx_data = rx_sh_new;
          next_r.rx_valid = 1'b1;
          rx_cnt_new = '0;
        end
      end
      next_r.rx_sh = rx_sh_new;
      next_r.rx_cnt = rx_cnt_new;
      next_r.rx_pend = rx_fs;
    end

    // pin drive
    if (port_enable_in) begin
      next_r.pin_out[`SSP_PIN_TXD] = r.tx_bits[0]; // see RQ1
      next_r.pin_oe[`SSP_PIN_TXD] = 1'b1;
      next_r.pin_out[`SSP_PIN_RXD] = 1'b0;
      next_r.pin_oe[`SSP_PIN_RXD] = 1'b0; // see RQ2
      next_r.pin_out[`SSP_PIN_SCK] = r.bclk;
      next_r.pin_oe[`SSP_PIN_SCK] = bit_clock_master_in; // see RQ3
      next_r.pin_out[`SSP_PIN_FS] = r.fs_gen; // see RQ11
      next_r.pin_oe[`SSP_PIN_FS] = frame_master_in; // see RQ10
      if (mode == ssp_pkg::SSP_MODE_ASYNC) begin
        // receiver clock and frame, each in or out
        next_r.pin_out[`SSP_PIN_CTL0] = r.bclk;
        next_r.pin_oe[`SSP_PIN_CTL0] = rx_clock_master_in; // see RQ6
        next_r.pin_out[`SSP_PIN_CTL1] = r.rxfs_gen;
        next_r.pin_oe[`SSP_PIN_CTL1] = rx_frame_master_in; // see RQ8
      end else begin
        // extra transmitter lanes or serial flags
        if (ctl_tx_lane_in[0]) begin
          next_r.pin_out[`SSP_PIN_CTL0] = r.tx_bits[1]; // see RQ7
          next_r.pin_oe[`SSP_PIN_CTL0] = 1'b1;
        end else begin
          next_r.pin_out[`SSP_PIN_CTL0] = flag_value_in[0]; // see RQ7
          next_r.pin_oe[`SSP_PIN_CTL0] = flag_dir_in[0];
        end
        if (ctl_tx_lane_in[1]) begin
          next_r.pin_out[`SSP_PIN_CTL1] = r.tx_bits[2]; // see RQ9
          next_r.pin_oe[`SSP_PIN_CTL1] = 1'b1;
        end else begin
          next_r.pin_out[`SSP_PIN_CTL1] = flag_value_in[1]; // see RQ9
          next_r.pin_oe[`SSP_PIN_CTL1] = flag_dir_in[1];
        end
      end
    end else begin
      // port idle: every pin is a plain general purpose line
      next_r.pin_out = gpio_data_in; // see RQ13
      next_r.pin_oe = gpio_dir_in; // see RQ13
      // drop any half-moved word so the next enable starts clean
      next_r.tx_cnt = '0;
      next_r.tx_pend = 1'b0;
      next_r.fs_gen = 1'b0;
      next_r.tx_bits = 3'h0;
      next_r.rx_cnt = '0;
      next_r.rx_pend = 1'b0;
      next_r.rxfs_gen = 1'b0;
      next_r.bclk = 1'b0;
      next_r.div_cnt = '0;
    end
  end

  // ==========================================================
  // state register; synchronous reset leaves every pin undriven
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      r <= '0;
      r.pin_out <= `SSP_RST_PIN_OUT;
      r.pin_oe <= `SSP_RST_PIN_OE;
    end else begin
      r <= next_r;
    end
  end

endmodule

//--- ssp_pins_props.sv
// assertion checker for the serial port pin block
`timescale 1ns/100ps
`include "ssp_params.svh"
module ssp_pins_props #(
  parameter int HALF_BIT_CYCLES = `SSP_HALF_BIT_CYCLES
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic port_enable_in,
  input wire logic sync_mode_in,
  input wire logic bit_clock_master_in,
  input wire logic frame_master_in,
  input wire logic rx_clock_master_in,
  input wire logic rx_frame_master_in,
  input wire logic [1:0] ctl_tx_lane_in,
  input wire logic [1:0] flag_dir_in,
  input wire logic [`SSP_PIN_COUNT-1:0] gpio_dir_in,
  input wire logic [`SSP_PIN_COUNT-1:0] gpio_data_in,
  input wire logic rx_valid_out,
  input wire logic [`SSP_PIN_COUNT-1:0] pin_out,
  input wire logic [`SSP_PIN_COUNT-1:0] pin_oe_out
);
  // ==========================================
  // high-time counters of bit clock and frame sync
  // they clear while the pins are general lines, since software data may sit high for any length
  logic [7:0] clk_hi;
  logic [7:0] fs_hi;
  always_ff @(posedge mclk_in) begin
    clk_hi <= (!nrst_in || !port_enable_in || !pin_out[2]) ? 8'h00 : clk_hi + 8'h01;
    fs_hi <= (!nrst_in || !port_enable_in || !pin_out[5]) ? 8'h00 : fs_hi + 8'h01;
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  // ==========================================
  // two cycles of one configuration, since pins are registered; s_quiet is eight cycles without a word strobe
  sequence s_gpio; !port_enable_in ##1 !port_enable_in; endsequence
  sequence s_on; port_enable_in ##1 port_enable_in; endsequence
  sequence s_async; port_enable_in && !sync_mode_in ##1 port_enable_in && !sync_mode_in; endsequence
  sequence s_sync; port_enable_in && sync_mode_in ##1 port_enable_in && sync_mode_in; endsequence
  sequence s_quiet; !rx_valid_out [*8]; endsequence
  // ==========================================
  // assertions
  a_gpio_oe: assert property (s_gpio |-> pin_oe_out == $past(gpio_dir_in))
    else $error("gpio enables wrong");
  a_gpio_data: assert property (s_gpio |-> (pin_out & pin_oe_out) == ($past(gpio_data_in) & pin_oe_out))
    else $error("gpio drive wrong");
  a_tx_drive: assert property (s_on |-> pin_oe_out[0])
    else $error("tx pin not driven");
  a_rx_input: assert property (s_on |-> !pin_oe_out[1])
    else $error("rx pin driven");
  a_clk_dir: assert property (s_on |-> pin_oe_out[2] == $past(bit_clock_master_in))
    else $error("bit clock direction wrong");
  a_fs_dir: assert property (s_on |-> pin_oe_out[5] == $past(frame_master_in))
    else $error("frame sync direction wrong");
  a_async_ctl: assert property (s_async |-> pin_oe_out[4] == $past(rx_frame_master_in) &&
    pin_oe_out[3] == $past(rx_clock_master_in)) else $error("async control pins wrong");
  a_sync_ctl: assert property (s_sync |-> pin_oe_out[4:3] == ($past(ctl_tx_lane_in) | $past(flag_dir_in)))
    else $error("sync control pins wrong");
  a_rx_pulse: assert property (rx_valid_out |=> s_quiet)
    else $error("rx valid too long or too soon");
  a_clk_half: assert property ($fell(pin_out[2]) && $past(pin_oe_out[2], 5) && $past(port_enable_in, 5) |->
    clk_hi == 8'(HALF_BIT_CYCLES)) else $error("bit clock high time wrong");
  a_fs_width: assert property ($fell(pin_out[5]) && $past(pin_oe_out[5], 9) && $past(port_enable_in, 9) |->
    fs_hi == 8'(2 * HALF_BIT_CYCLES)) else $error("frame sync width wrong");
endmodule
bind ssp_pins ssp_pins_props #(.HALF_BIT_CYCLES(HALF_BIT_CYCLES)) u_props (
  .mclk_in, .nrst_in, .port_enable_in, .sync_mode_in, .bit_clock_master_in, .frame_master_in,
  .rx_clock_master_in, .rx_frame_master_in, .ctl_tx_lane_in, .flag_dir_in, .gpio_dir_in,
  .gpio_data_in, .rx_valid_out, .pin_out, .pin_oe_out);

//--- ssp_peer.sv
// peer codec model facing the serial port pins
`timescale 1ns/100ps
`include "ssp_params.svh"
module ssp_peer (
  input wire logic [`SSP_PIN_COUNT-1:0] pin_out_in,
  input wire logic [`SSP_PIN_COUNT-1:0] pin_oe_in,
  input wire logic [1:0] flag_level_in,
  input wire logic [15:0] send_word_in,
  output logic [`SSP_PIN_COUNT-1:0] pin_level_out,
  output logic [15:0] got0_out = 16'h0000,
  output logic [15:0] got1_out = 16'h0000,
  output logic [15:0] got2_out = 16'h0000,
  output int words_out = 0
);
  // ==========================================
  // peer drive state; clock idles low between frames
  logic sck = 1'b0;
  logic fs = 1'b0;
  logic rxd = 1'b0;
  logic pend = 1'b0;
  logic [15:0] sh = 16'h0000;
  int cnt = 0;
  // each wire shows whoever enables it; tx pin idles high
  assign pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & {fs, flag_level_in, sck, rxd, 1'b1});
  // ==========================================
  // both bit clock edges: capture on fall, launch on rise
  always @(pin_level_out[2]) begin
    if (!pin_level_out[2]) begin
      if (cnt != 0) begin
        got0_out = {got0_out[14:0], pin_level_out[0]};
        got1_out = {got1_out[14:0], pin_level_out[3]};
        got2_out = {got2_out[14:0], pin_level_out[4]};
        cnt--;
        if (cnt == 0) words_out++;
      end
      if (pin_level_out[5]) pend = 1'b1;
    end else if (pend) begin
      pend = 1'b0;
      cnt = 16;
      sh = send_word_in;
      rxd = sh[15];
    end else if (cnt != 0) begin
      sh = sh << 1;
      rxd = sh[15];
    end else begin
      // released line toggles so no stale bit looks valid
      rxd = ~rxd;
    end
  end
  // one bit period of the gated clock
  task automatic tick();
    #80 sck = 1'b1;
    #160 sck = 1'b0;
    #80;
  endtask
  // back-to-back words, sync one bit early, clock stops after
  task automatic run_frames(input int n);
    fs = 1'b1;
    tick();
    for (int w = 0; w < n; w++) begin
      for (int b = 0; b < 16; b++) begin
        fs = (b == 15) && (w < n - 1);
        tick();
      end
    end
    fs = 1'b0;
  endtask
endmodule

//--- testbench.sv
// self-checking bench for the serial port pin block
`timescale 1ns/100ps
`include "ssp_params.svh"
module testbench;
  // ==========================================
  // stimulus and observation
  localparam int NP = `SSP_PIN_COUNT;
  logic mclk_in = 1'b0, nrst_in = 1'b0, port_enable_in = 1'b0, sync_mode_in = 1'b1, tx_valid_in = 1'b0;
  logic bit_clock_master_in = 1'b1, clock_gated_in = 1'b1, frame_master_in = 1'b1;
  logic rx_clock_master_in = 1'b0, rx_frame_master_in = 1'b0, tx_ready_out, rx_valid_out;
  logic [1:0] ctl_tx_lane_in = 2'h3, flag_dir_in = 2'h0, flag_value_in = 2'h0, flag_level = 2'h1, flag_state_out;
  logic [NP-1:0] gpio_dir_in = 6'h00, gpio_data_in = 6'h00, gpio_level_out, pin_in, pin_out, pin_oe_out;
  logic [15:0] tx_data_in = 16'h0000, tx1_data_in = 16'h0000, tx2_data_in = 16'h0000;
  logic [15:0] rx_data_out, send_word = 16'h0000, got0, got1, got2;
  int failures = 0, checks_done = 0, words, rx_count = 0, rises = 0;
  logic [15:0] seen [$];
  ssp_pins uut (.mclk_in, .nrst_in, .port_enable_in, .sync_mode_in, .bit_clock_master_in, .clock_gated_in,
    .frame_master_in, .rx_clock_master_in, .rx_frame_master_in, .ctl_tx_lane_in, .flag_dir_in, .flag_value_in,
    .flag_state_out, .gpio_dir_in, .gpio_data_in, .gpio_level_out, .tx_valid_in, .tx_ready_out, .tx_data_in,
    .tx1_data_in, .tx2_data_in, .rx_valid_out, .rx_data_out, .pin_in, .pin_out, .pin_oe_out);
  ssp_peer peer (.pin_out_in(pin_out), .pin_oe_in(pin_oe_out), .flag_level_in(flag_level),
    .send_word_in(send_word), .pin_level_out(pin_in), .got0_out(got0), .got1_out(got1), .got2_out(got2),
    .words_out(words));
  initial forever #20 mclk_in = ~mclk_in;
  // rx_count sampled mid-cycle, away from the launching edge
  always @(negedge mclk_in) if (rx_valid_out === 1'b1) rx_count++;
  always @(posedge pin_in[2]) rises++;
  always @(words) seen.push_back(got0);
  // ==========================================
  // shared tasks
  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #2;
  endtask
  task automatic check(input string what, input logic [15:0] seen_v, input logic [15:0] exp_v);
    checks_done++;
    if (seen_v !== exp_v) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp_v, seen_v);
    end
  endtask
  task automatic stop_test();
    if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // valid is left high so back-to-back pushes never pulse it
  task automatic push(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    tx_data_in = a;
    tx1_data_in = b;
    tx2_data_in = c;
    tx_valid_in = 1'b1;
    step(1);
  endtask
  task automatic wait_rx(input int n);
    for (int i = 0; i < 1000 && rx_count < n; i++) step(1);
    check("rx count", 16'(rx_count), 16'(n));
  endtask
  // ==========================================
  // scenarios
  task automatic t_gpio();
    gpio_dir_in = 6'h15;
    gpio_data_in = 6'h3F;
    step(6);
    check("gpio oe", 16'(pin_oe_out), 16'h0015);
    check("gpio out", 16'(pin_out & 6'h15), 16'h0015);
    check("gpio level", 16'(gpio_level_out & 6'h3D), 16'h001D);
    gpio_dir_in = 6'h00;
    step(4);
    check("gpio off", 16'(pin_oe_out), 16'h0000);
  endtask
  task automatic t_master();
    int c;
    port_enable_in = 1'b1;
    send_word = 16'h3C5A;
    step(2);
    c = rx_count;
    push(16'hA5C3, 16'h1234, 16'h0F0F);
    tx_valid_in = 1'b0;
    wait_rx(c + 1);
    check("rx word", rx_data_out, 16'h3C5A);
    check("lane0", got0, 16'hA5C3);
    check("lane1", got1, 16'h1234);
    check("lane2", got2, 16'h0F0F);
    step(30);
    c = rises;
    step(64);
    check("gated idle", 16'(rises - c), 16'h0000);
    clock_gated_in = 1'b0;
    step(8);
    c = rises;
    step(64);
    check("free clock", 16'(rises - c), 16'h0008);
    clock_gated_in = 1'b1;
    step(300);
  endtask
  // peer clocks and frames; buffer fills, refuses, drains
  task automatic t_fifo();
    int c;
    bit_clock_master_in = 1'b0;
    frame_master_in = 1'b0;
    step(4);
    for (int i = 0; i < 8; i++) push(16'h8001 + 16'(i), 16'h4000, 16'h2000);
    check("full ready", 16'(tx_ready_out), 16'h0000);
    push(16'hDEAD, 16'h0000, 16'h0000);
    tx_valid_in = 1'b0;
    seen.delete();
    send_word = 16'hC3A5;
    c = rx_count;
    peer.run_frames(9);
    step(8);
    check("tx words", 16'(seen.size()), 16'h0009);
    for (int i = 0; i < 9; i++) check("tx order", seen[i], (i < 8) ? 16'h8001 + 16'(i) : 16'h0000);
    check("rx words", 16'(rx_count - c), 16'h0009);
    check("rx last", rx_data_out, 16'hC3A5);
    check("drain ready", 16'(tx_ready_out), 16'h0001);
  endtask
  task automatic t_modes();
    bit_clock_master_in = 1'b1;
    sync_mode_in = 1'b0;
    rx_clock_master_in = 1'b1;
    rx_frame_master_in = 1'b1;
    step(3);
    check("async out", 16'(pin_oe_out[4:3]), 16'h0003);
    rx_clock_master_in = 1'b0;
    rx_frame_master_in = 1'b0;
    step(3);
    check("async in", 16'(pin_oe_out[4:3]), 16'h0000);
    sync_mode_in = 1'b1;
    ctl_tx_lane_in = 2'h0;
    flag_dir_in = 2'h3;
    flag_value_in = 2'h2;
    step(3);
    check("flag out", 16'({pin_oe_out[4:3], pin_out[4:3]}), 16'h000E);
    flag_dir_in = 2'h0;
    step(6);
    check("flag in", 16'(flag_state_out), 16'h0001);
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    step(6);
    check("reset oe", 16'(pin_oe_out), 16'h0000);
    check("reset ready", 16'(tx_ready_out), 16'h0001);
    check("reset rx", rx_data_out, 16'h0000);
    nrst_in = 1'b1;
    t_gpio();
    t_master();
    t_fifo();
    t_modes();
    stop_test();
  end
  initial begin
    #400000;
    failures++;
    stop_test();
  end
endmodule
